// file: wdsc_pkg.sv
// wdsc_pkg: constants, register map and types of the watchdog/sleep/config block
package wdsc_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // clock and timing
  localparam int unsigned SYS_CLK_HZ     = 100_000_000;
  localparam int unsigned DRT_MS         = 18;
  localparam int unsigned DRT_CYCLES     = DRT_MS * (SYS_CLK_HZ / 1000);
  localparam int unsigned WDT_BASE_MS    = 18;
  localparam int unsigned WDT_OSC_KHZ    = 32;
  localparam int unsigned WDT_BASE_TICKS = WDT_BASE_MS * WDT_OSC_KHZ;
  ////////////////////////////////////////////////////////////////////////////
  // register map, byte addresses
  localparam logic [3:0] ADDR_OPTION = 4'h0;
  localparam logic [3:0] ADDR_CONFIG = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_CMD    = 4'hC;
  // option register
  localparam int unsigned OPT_W        = 6;
  localparam logic [5:0]  OPT_RESET    = 6'h3F;
  localparam int unsigned OPT_ASSIGN_B = 3;
  localparam int unsigned OPT_RATIO_LO = 0;
  // configuration word
  localparam int unsigned CFG_W        = 12;
  localparam int unsigned CFG_WATCHDOG_ENABLE_FUSE_B   = 2;
  localparam int unsigned CFG_CP_LO    = 3;
  localparam int unsigned CFG_CP_HI    = 11;
  localparam int unsigned CFG_OLD_HI   = 4;
  // status register bits
  localparam int unsigned ST_TO_N_B    = 4;
  localparam int unsigned ST_PD_N_B    = 3;
  localparam int unsigned ST_SLEEP_B   = 0;
  localparam int unsigned ST_HOLD_B    = 1;
  // command register bits
  localparam int unsigned CMD_WATCHDOG_CLEAR_INSTR_B = 0;
  localparam int unsigned CMD_SLEEP_B  = 1;
  localparam int unsigned CMD_TMRWR_B  = 2;
  ////////////////////////////////////////////////////////////////////////////
  // types
  localparam int unsigned DIV_W = 8;
  typedef enum logic [1:0] {
    OSC_LOW_POWER_CRYSTAL,
    OSC_STANDARD_CRYSTAL,
    OSC_HIGH_SPEED_CRYSTAL,
    OSC_RC
  } wdsc_osc_e;
  typedef struct packed {
    logic       io_hold;
    logic       main_osc_drive_en;
    logic       cpu_reset;
    logic       timeout_flag_n;
    logic       powerdown_flag_n;
  } wdsc_state_s;
endpackage : wdsc_pkg

// file: wdsc_top.sv
// wdsc_top: watchdog, shared divider, sleep control and configuration word
//
// The register addresses and register access over Avalon-MM were decided locally.
`timescale 1ns/1ns
// Function
// RULE_01 - configuration bit 2 high enables watchdog; low disables it for good
// RULE_02 - configuration bits 1:0 pick oscillator: low-power, standard, high-speed, RC
// RULE_03 - newer parts: configuration bits 11..3 are active-low code protection
// RULE_04 - older parts: bits 11..4 read zero, single active-low protect bit 3
// RULE_05 - watchdog counts on its own oscillator, also while main clock stops
// RULE_06 - watchdog time-out resets the device, awake or asleep (wake-up)
// RULE_07 - watchdog time-out reset clears the active-low time-out flag
// RULE_08 - one 8-bit divider serves timer or watchdog, the other runs undivided
// RULE_09 - option bits 3:0 hold divider assignment and three ratio bits
// RULE_10 - assignment bit low gives divider to timer, high to watchdog
// RULE_11 - watchdog base period 18 ms, divider extends it up to 1:128
// RULE_12 - clear command zeroes watchdog and its divider, preventing time-out
// RULE_13 - sleep command zeroes watchdog and its divider for longest sleep
// RULE_14 - sleep entry: watchdog from zero, time-out flag set, power-down cleared, osc off
// RULE_15 - pins keep their drive state throughout sleep
// RULE_16 - watchdog reset stays internal, master-clear pin never driven
// RULE_17 - sleep ends only by master-clear or enabled watchdog time-out, both reset
// RULE_18 - power-down flag set at power-up, cleared on sleep entry
// RULE_19 - watchdog counter cleared on leaving sleep, whatever the cause
// RULE_20 - reset delay timer holds the device in reset 18 ms after reset
// RULE_21 - tick count write clears divider when timer owns it; divider zero on reset
// RULE_22 - configuration word sampled once, constant during execution
// RULE_23 - option resets to all ones: divider to watchdog, maximum ratio
module wdsc_top
  import wdsc_pkg::*;
#(
  parameter int unsigned DRT_LEN    = DRT_CYCLES,
  parameter int unsigned WDT_LEN    = WDT_BASE_TICKS,
  parameter bit          NEW_VARIANT = 1'b1
) (
  // clock, reset, enable
  input  wire logic                 sys_clk,
  input  wire logic                 nrst,
  input  wire logic                 clk_en,
  // avalon-mm slave
  input  wire logic [3:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  output logic      [31:0]          avs_readdata,
  output logic                      avs_waitrequest,
  // pins and non-volatile storage
  input  wire logic                 master_clear_pin_n,
  input  wire logic                 wdt_osc_in,
  input  wire logic [CFG_W-1:0]     cfg_word_in,
  // timer side
  input  wire logic                 tmr_src_tick,
  output logic                      tmr_inc,
  // device control and status
  output wdsc_state_s               dev_state,
  output wdsc_osc_e                 osc_type_select,
  output logic                      code_protect_active
);
  import wdsc_pkg::*;

  typedef enum logic [1:0] {PH_HOLD, PH_RUN, PH_SLEEP} wdsc_phase_e;

  // low-bit mask of a divider ratio: value 2**(n) - 1, the low n stages must be full
  function automatic logic [DIV_W-1:0] ratio_mask(input logic [3:0] n);
    ratio_mask = DIV_W'((9'h001 << n) - 9'h001);
  endfunction : ratio_mask

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] mclr_sync_r;
  logic [1:0] wosc_sync_r;
  logic       wosc_last_r;
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      mclr_sync_r <= 2'h3;
      wosc_sync_r <= 2'h0;
      wosc_last_r <= 1'b0;
    end else if (clk_en) begin
      mclr_sync_r <= {mclr_sync_r[0], master_clear_pin_n};
      wosc_sync_r <= {wosc_sync_r[0], wdt_osc_in};
      wosc_last_r <= wosc_sync_r[1];
    end
  end
  wire mclr_active = ~mclr_sync_r[1];
  // one tick per rising edge of the watchdog's own oscillator, even in sleep
  wire wosc_tick   = wosc_sync_r[1] & ~wosc_last_r;   // see RULE_05

  ////////////////////////////////////////////////////////////////////////////
  // configuration word, sampled once after power-up release
  logic [CFG_W-1:0] cfg_r;
  logic             cfg_valid_r;
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cfg_r       <= '0;
      cfg_valid_r <= 1'b0;
    end else if (clk_en && !cfg_valid_r) begin
      cfg_r       <= cfg_word_in;   // see RULE_22
      cfg_valid_r <= 1'b1;
    end
  end
  wire [CFG_W-1:0] cfg_view = NEW_VARIANT ? cfg_r
                            : {{(CFG_W-CFG_OLD_HI){1'b0}}, cfg_r[CFG_OLD_HI-1:0]};  // see RULE_04
  wire wdt_enabled = cfg_valid_r & cfg_r[CFG_WATCHDOG_ENABLE_FUSE_B];   // see RULE_01
  assign osc_type_select = wdsc_osc_e'(cfg_r[1:0]);     // see RULE_02
  assign code_protect_active = NEW_VARIANT ? ~&cfg_r[CFG_CP_HI:CFG_CP_LO]  // see RULE_03
                             : ~cfg_r[CFG_CP_LO];                        // see RULE_04

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: one wait cycle, then answer
  logic        ack_r;
  logic [31:0] rdata_r;
  logic [OPT_W-1:0] opt_r;
  logic        to_n_r;
  logic        pd_n_r;
  wdsc_phase_e phase_r;
  wire bus_req   = avs_read | avs_write;
  wire bus_fire  = bus_req & ack_r & clk_en;
  wire wr_fire   = bus_fire & avs_write;
  wire wr_opt    = wr_fire & (avs_address == ADDR_OPTION);
  wire wr_cmd    = wr_fire & (avs_address == ADDR_CMD);
  wire cmd_clr   = wr_cmd & avs_writedata[CMD_WATCHDOG_CLEAR_INSTR_B];
  wire cmd_sleep = wr_cmd & avs_writedata[CMD_SLEEP_B] & (phase_r == PH_RUN);
  wire cmd_tmrwr = wr_cmd & avs_writedata[CMD_TMRWR_B];
  assign avs_waitrequest = bus_req & ~ack_r;
  assign avs_readdata    = rdata_r;

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    case (avs_address)
      ADDR_OPTION: rd_mux[OPT_W-1:0] = opt_r;
      ADDR_CONFIG: rd_mux[CFG_W-1:0] = cfg_view;
      ADDR_STATUS: begin
        rd_mux[ST_TO_N_B]  = to_n_r;
        rd_mux[ST_PD_N_B]  = pd_n_r;
        rd_mux[ST_SLEEP_B] = (phase_r == PH_SLEEP);
        rd_mux[ST_HOLD_B]  = (phase_r == PH_HOLD);
      end
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0;
    end else if (clk_en) begin
      ack_r <= bus_req & ~ack_r;
      if (bus_req && !ack_r) begin
        rdata_r <= rd_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared divider and watchdog counter
  wire div_to_wdt = opt_r[OPT_ASSIGN_B];                          // see RULE_10
  wire [2:0] ratio = opt_r[OPT_RATIO_LO +: 3];                    // see RULE_09
  logic [DIV_W-1:0] div_r;
  logic [23:0]      wdt_cnt_r;
  logic             dev_rst;
  logic             wake_evt;
  wire base_wrap   = wosc_tick & (wdt_cnt_r == 24'(WDT_LEN - 1));
  // timer owns divider: 1:2 .. 1:256; watchdog owns it: 1:1 .. 1:128
  wire tmr_div_end = &(div_r | ~ratio_mask({1'b0, ratio} + 4'h1));
  wire wdt_div_end = &(div_r | ~ratio_mask({1'b0, ratio}));
  assign tmr_inc   = tmr_src_tick & clk_en & (div_to_wdt | tmr_div_end);   // see RULE_08
  wire wdt_timeout = wdt_enabled & base_wrap & (~div_to_wdt | wdt_div_end); // see RULE_11
  // clear, sleep entry and wake all restart the watchdog from zero
  wire wdt_clr     = cmd_clr | cmd_sleep | wake_evt | dev_rst;  // see RULE_12 RULE_13 RULE_19
  wire div_clr     = dev_rst | (div_to_wdt & wdt_clr)           // see RULE_12 RULE_13
                   | (~div_to_wdt & cmd_tmrwr);                 // see RULE_21

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      wdt_cnt_r <= 24'h0;
      div_r     <= 8'h00;                                       // see RULE_21
    end else if (clk_en) begin
      if (wdt_clr || !wdt_enabled) begin
        wdt_cnt_r <= 24'h0;
      end else if (wosc_tick) begin
        wdt_cnt_r <= base_wrap ? 24'h0 : wdt_cnt_r + 24'h1;
      end
      if (div_clr) begin
        div_r <= 8'h00;
      end else if (div_to_wdt ? base_wrap : tmr_src_tick) begin
        div_r <= div_r + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // option register, reset to all ones on every device reset
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      opt_r <= OPT_RESET;                                       // see RULE_23
    end else if (clk_en) begin
      if (dev_rst) begin
        opt_r <= OPT_RESET;                                     // see RULE_23
      end else if (wr_opt) begin
        opt_r <= avs_writedata[OPT_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset sources, sleep and reset delay timer
  // the master-clear pin is an input only: a watchdog reset is never driven out
  assign dev_rst  = wdt_timeout | mclr_active;                  // see RULE_06 RULE_16
  assign wake_evt = (phase_r == PH_SLEEP) & dev_rst;            // see RULE_17
  logic [23:0] drt_cnt_r;
  wire drt_done = (drt_cnt_r == 24'(DRT_LEN - 1));

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      phase_r   <= PH_HOLD;
      drt_cnt_r <= 24'h0;
    end else if (clk_en) begin
      case (phase_r)
        PH_HOLD: begin
          // held while master-clear stays low, then the full delay
          if (mclr_active || wdt_timeout) begin
            drt_cnt_r <= 24'h0;
          end else if (drt_done) begin
            phase_r <= PH_RUN;                                  // see RULE_20
          end else begin
            drt_cnt_r <= drt_cnt_r + 24'h1;
          end
        end
        PH_RUN: begin
          drt_cnt_r <= 24'h0;
          if (dev_rst) begin
            phase_r <= PH_HOLD;                                 // see RULE_06
          end else if (cmd_sleep) begin
            phase_r <= PH_SLEEP;
          end
        end
        PH_SLEEP: begin
          drt_cnt_r <= 24'h0;
          if (wake_evt) begin
            phase_r <= PH_HOLD;                                 // see RULE_17
          end
        end
        default: phase_r <= PH_HOLD;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset-cause flags; a time-out in the clearing cycle still wins
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      to_n_r <= 1'b1;
      pd_n_r <= 1'b1;                                           // see RULE_18
    end else if (clk_en) begin
      if (wdt_timeout) begin
        to_n_r <= 1'b0;                                         // see RULE_07
      end else if (cmd_sleep || cmd_clr) begin
        to_n_r <= 1'b1;                                         // see RULE_14
      end
      if (cmd_sleep) begin
        pd_n_r <= 1'b0;                                         // see RULE_14 RULE_18
      end else if (cmd_clr) begin
        pd_n_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // device control outputs
  always_comb begin
    dev_state.io_hold           = (phase_r == PH_SLEEP);       // see RULE_15
    dev_state.main_osc_drive_en = (phase_r != PH_SLEEP);       // see RULE_14
    dev_state.cpu_reset         = (phase_r == PH_HOLD);        // see RULE_20
    dev_state.timeout_flag_n    = to_n_r;
    dev_state.powerdown_flag_n  = pd_n_r;
  end
endmodule : wdsc_top

// file: wdsc_notes_unused.sv
// wdsc_notes_unused: intentionally empty design unit
`timescale 1ns/1ns

// file: wdsc_monitor.sv
// wdsc_monitor: port-level checks of wdsc_top
`timescale 1ns/1ns
module wdsc_monitor #(
  parameter int unsigned DRT_LEN = 20
) (
  // clock and reset
  input wire logic                  sys_clk,
  input wire logic                  nrst,
  // bus and pin
  input wire logic [3:0]            avs_address,
  input wire logic                  avs_read,
  input wire logic [31:0]           avs_readdata,
  input wire logic                  avs_waitrequest,
  input wire logic                  master_clear_pin_n,
  // device state
  input wire wdsc_pkg::wdsc_state_s dev_state,
  input wire wdsc_pkg::wdsc_osc_e   osc_type_select,
  input wire logic                  code_protect_active
);
  import wdsc_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // length of the current reset hold; pin-held holds only make it longer
  int unsigned hold_n;
  always_ff @(posedge sys_clk) begin
    if (!nrst || !dev_state.cpu_reset) hold_n <= 0;
    else hold_n <= hold_n + 1;
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  cfg_stable_a: assert property (
    $past(nrst, 2) |-> $stable(osc_type_select) && $stable(code_protect_active))
    else $error("config outputs changed during run");
  osc_read_a: assert property (
    avs_read && !avs_waitrequest && avs_address == ADDR_CONFIG
    |-> avs_readdata[1:0] == osc_type_select) else $error("oscillator type mismatch");
  protect_read_a: assert property (
    avs_read && !avs_waitrequest && avs_address == ADDR_CONFIG
    |-> code_protect_active == (avs_readdata[11:3] != 9'h1FF)) else $error("protect wrong");
  sleep_flags_a: assert property (
    $rose(dev_state.io_hold) |-> ##[0:2]
    (!dev_state.powerdown_flag_n && dev_state.timeout_flag_n)) else $error("sleep flags");
  osc_off_a: assert property (
    dev_state.io_hold |-> !dev_state.main_osc_drive_en) else $error("osc runs in sleep");
  sleep_exit_a: assert property (
    $fell(dev_state.io_hold) |-> dev_state.cpu_reset) else $error("sleep left without reset");
  to_reset_a: assert property (
    $fell(dev_state.timeout_flag_n) |-> dev_state.cpu_reset) else $error("time-out flag");
  pin_wake_a: assert property (
    dev_state.io_hold && !master_clear_pin_n |-> ##[1:5] dev_state.cpu_reset)
    else $error("no wake on master clear");
  drt_hold_a: assert property (
    $fell(dev_state.cpu_reset) |-> hold_n >= DRT_LEN) else $error("reset hold too short");
endmodule : wdsc_monitor
bind wdsc_top wdsc_monitor #(.DRT_LEN(DRT_LEN)) u_mon (.sys_clk(sys_clk), .nrst(nrst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .master_clear_pin_n(master_clear_pin_n),
  .dev_state(dev_state), .osc_type_select(osc_type_select),
  .code_protect_active(code_protect_active));

// file: wdsc_cpu_model.sv
// wdsc_cpu_model: core side issuing option, clear and sleep accesses
`timescale 1ns/1ns
module wdsc_cpu_model (
  // clock
  input  wire logic        sys_clk,
  // avalon-mm master
  output logic [3:0]       avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic [31:0]      avs_writedata,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);
  import wdsc_pkg::*;
  initial begin
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
  end
  // one idle edge after each access, so no signal is set twice in a step
  task automatic access(input logic w, input logic [3:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    while (!ok && n < 50) begin
      @(negedge sys_clk);
      ok = !avs_waitrequest;
      @(posedge sys_clk);
      n++;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask : access
endmodule : wdsc_cpu_model

// file: watchdog_sleep_config_test.sv
// watchdog_sleep_config_test: register-level test of wdsc_top
`timescale 1ns/1ns
module watchdog_sleep_config_test;
  import wdsc_pkg::*;
  logic sys_clk = 1'b0, nrst = 1'b0, clk_en = 1'b1, mclr_n = 1'b1;
  logic wdt_osc = 1'b0, tick = 1'b0, tmr_inc, code_prot;
  logic [2:0] div = 3'h0;
  logic [11:0] cfg = 12'hFF5;
  logic [3:0] adr;
  logic rd, wr_en, wq;
  logic [31:0] wd, rdat;
  wdsc_state_s st;
  wdsc_osc_e osc;
  int n_errors = 0, compares = 0, n;
  logic [31:0] opts [4] = '{32'h0, 32'h1, 32'h2, 32'h8};
  int incs [4] = '{4, 2, 1, 8};
  wdsc_top #(.DRT_LEN(20), .WDT_LEN(4), .NEW_VARIANT(1'b1)) uut (.sys_clk(sys_clk),
    .nrst(nrst), .clk_en(clk_en), .avs_address(adr), .avs_read(rd), .avs_write(wr_en),
    .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wq),
    .master_clear_pin_n(mclr_n), .wdt_osc_in(wdt_osc), .cfg_word_in(cfg),
    .tmr_src_tick(tick), .tmr_inc(tmr_inc), .dev_state(st), .osc_type_select(osc),
    .code_protect_active(code_prot));
  wdsc_cpu_model cpu (.sys_clk(sys_clk), .avs_address(adr), .avs_read(rd),
    .avs_write(wr_en), .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wq));
  ////////////////////////////////////////////////////////////////////////////
  always #5 sys_clk = ~sys_clk;
  // watchdog oscillator runs free, also while the main clock is gated
  always @(posedge sys_clk) begin
    div <= div + 3'h1;
    wdt_osc <= div[2];
    tick <= (div == 3'h0);
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [31:0] exp);
    logic [31:0] q;
    logic ok;
    cpu.access(w, a, d, q, ok);
    check("bus answer", ok, 1'b1);
    if (!ok) print_verdict();
    if (!w) check($sformatf("reg %h", a), q, exp);
  endtask : acc
  task automatic wait_rst(input logic v);
    int k;
    k = 0;
    do begin
      @(negedge sys_clk);
      k++;
    end while (st.cpu_reset !== v && k < 200);
    @(posedge sys_clk);
    check("cpu_reset", st.cpu_reset, v);
    if (k == 200) print_verdict();
  endtask : wait_rst
  task automatic hold_at(input logic v);
    @(negedge sys_clk);
    check("cpu_reset", st.cpu_reset, v);
    @(posedge sys_clk);
  endtask : hold_at
  task automatic rst(input logic [11:0] c);
    nrst <= 1'b0;
    cfg <= c;
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
  endtask : rst
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst(12'hFF5);
    acc(0, ADDR_STATUS, 0, 32'h1A);
    acc(1, ADDR_CONFIG, 0, 0);
    acc(0, ADDR_CONFIG, 0, 32'hFF5);
    acc(0, ADDR_OPTION, 0, 32'h3F);
    acc(0, 4'h2, 0, 0);
    check("osc", osc, OSC_STANDARD_CRYSTAL);
    check("protect", code_prot, 1'b1);
    wait_rst(0);
    for (int r = 0; r < 2; r++) begin
      // restart the watchdog first so the new, shorter ratio cannot fire at once
      acc(1, ADDR_CMD, 32'h1, 0);
      acc(1, ADDR_OPTION, 32'h8 | r, 0);
      repeat (4) begin
        acc(1, ADDR_CMD, 32'h1, 0);
        repeat (14) @(posedge sys_clk);
      end
      hold_at(0);
      // earliest time-out is 25 (or 57) edges after the last clear
      repeat (32 * (1 << r) - 24) @(posedge sys_clk);
      hold_at(0);
      wait_rst(1);
      acc(0, ADDR_STATUS, 0, 32'h0A);
      acc(0, ADDR_OPTION, 0, 32'h3F);
      wait_rst(0);
    end
    acc(1, ADDR_CMD, 32'h1, 0);
    acc(1, ADDR_OPTION, 32'h8, 0);
    acc(1, ADDR_CMD, 32'h1, 0);
    repeat (18) @(posedge sys_clk);
    acc(1, ADDR_CMD, 32'h2, 0);
    acc(0, ADDR_STATUS, 0, 32'h11);
    repeat (16) @(posedge sys_clk);
    hold_at(0);
    wait_rst(1);
    acc(0, ADDR_STATUS, 0, 32'h02);
    wait_rst(0);
    acc(1, ADDR_CMD, 32'h2, 0);
    mclr_n <= 1'b0;
    wait_rst(1);
    mclr_n <= 1'b1;
    acc(0, ADDR_STATUS, 0, 32'h12);
    wait_rst(0);
    rst(12'hFF1);
    wait_rst(0);
    acc(1, ADDR_OPTION, 32'h8, 0);
    repeat (100) @(posedge sys_clk);
    hold_at(0);
    // timer divider runs with the watchdog off, so no time-out cuts a window
    foreach (opts[i]) begin
      acc(1, ADDR_OPTION, opts[i], 0);
      n = 0;
      repeat (64) begin
        @(negedge sys_clk);
        n += tmr_inc;
      end
      @(posedge sys_clk);
      check("tmr_inc count", n, incs[i]);
    end
    print_verdict();
  end
endmodule : watchdog_sleep_config_test
